// ===== dv/testbench.sv
// self-checking bench: both link ends joined, plus a far end driven by hand
`timescale 1ns/1ps
module testbench import uaf_pkg::*;;
  localparam int BAUD = 12_500_000;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic text_mode = 1'b1, evt_req = 1'b0, profile_req = 1'b0, no_sleep = 1'b0, cmd_req = 1'b0;
  logic [7:0] evt_group = 8'h00, evt_id = 8'h00, h_group = 8'h00, h_id = 8'h00, h_arg = 8'h00;
  logic [15:0] evt_data = 16'h0000;
  logic evt_ready, cmd_stb, cmd_bad, sleeping, api_active, cmd_ready, pkt_stb, pkt_evt, pkt_bad;
  logic [7:0] cmd_group, cmd_id, pkt_group, pkt_id, d2_group, d2_id, last0, last1;
  logic [10:0] cmd_len, pkt_len, d2_len;
  logic [15:0] pkt_data;
  logic d2_stb, d2_bad;
  logic [44:0] host_q[$];
  logic [26:0] dev_q[$];
  logic [7:0] frm [7] = '{8'h00, 8'h02, 8'h05, 8'h06, 8'h01, 8'h09, 8'h00};
  int nbytes = 0, n_bad = 0, n_good = 0;
  int fail_count = 0;
  int samples_checked = 0;
  uaf_link_if link();
  uaf_link_if lk2();
  uaf_device #(.BAUD(BAUD)) uaf_device_i (.clock, .sys_rst, .link(link), .text_mode, .evt_req, .evt_group,
    .evt_id, .evt_data, .evt_ready, .cmd_stb, .cmd_bad, .cmd_group, .cmd_id, .cmd_len, .sleeping, .api_active);
  uaf_host #(.BAUD(BAUD)) uaf_host_i (.clock, .sys_rst, .link(link), .text_mode, .profile_req, .no_sleep,
    .cmd_req, .cmd_group(h_group), .cmd_id(h_id), .cmd_arg(h_arg), .cmd_ready, .pkt_stb, .pkt_evt, .pkt_group,
    .pkt_id, .pkt_len, .pkt_data, .pkt_bad);
  uaf_device #(.BAUD(BAUD)) uaf_device_i2 (.clock, .sys_rst, .link(lk2), .text_mode(1'b0), .evt_req(1'b0),
    .evt_group(8'h00), .evt_id(8'h00), .evt_data(16'h0000), .evt_ready(), .cmd_stb(d2_stb), .cmd_bad(d2_bad),
    .cmd_group(d2_group), .cmd_id(d2_id), .cmd_len(d2_len), .sleeping(), .api_active());
  uaf_link_sva uaf_link_sva_i (.clock, .sys_rst, .d2h_byte(link.d2h_byte), .d2h_stb(link.d2h_stb),
    .h2d_byte(link.h2d_byte), .h2d_stb(link.h2d_stb), .dev_rts(link.dev_rts), .host_rts(link.host_rts),
    .serial_profile_select_n(link.serial_profile_select_n), .low_power_select(link.low_power_select));
  // 25 MHz clock
  always #20 clock = ~clock;
  // one comparison, counted
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // bounded wait until every noted result arrived and both ends idle
  task automatic settle(input int lim);
    int n;
    n = 0;
    while ((host_q.size() != 0 || dev_q.size() != 0 || cmd_ready !== 1'b1 || evt_ready !== 1'b1) && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (n >= lim) begin
      check(1'b0, "wait ran out");
      finish_test();
    end
  endtask : settle
  // host command, with its notes
  task automatic send_cmd(input logic [7:0] g, input logic [7:0] i);
    dev_q.push_back(text_mode ? 27'h0 : {g, i, CMD_LEN});
    host_q.push_back(text_mode ? 45'h0 : {2'b10, g, i, RSP_LEN, RESULT_OK});
    @(posedge clock);
    h_group <= g;
    h_id <= i;
    h_arg <= 8'($urandom);
    cmd_req <= 1'b1;
    @(posedge clock);
    cmd_req <= 1'b0;
  endtask : send_cmd
  // user event, with its note
  task automatic send_evt(input logic [7:0] g, input logic [7:0] i, input logic [15:0] d);
    host_q.push_back(text_mode ? {2'b01, 43'h0} : {2'b11, g, i, EVT_LEN, d});
    evt_group <= g;
    evt_id <= i;
    evt_data <= d;
    evt_req <= 1'b1;
    @(posedge clock);
    evt_req <= 1'b0;
  endtask : send_evt
  // watcher: compares each arriving result with the oldest note
  always @(negedge clock) begin
    logic [44:0] e;
    if (link.d2h_stb === 1'b1) begin
      last1 = last0;
      last0 = link.d2h_byte;
      nbytes++;
    end
    if (pkt_stb === 1'b1 || pkt_bad === 1'b1) begin
      if (host_q.size() == 0) check(1'b0, "packet with none expected");
      else begin
        e = host_q.pop_front();
        check(pkt_stb === 1'b1 && {pkt_evt, pkt_group, pkt_id, pkt_len} === e[43:16], "packet fields");
        if (e[44]) check(pkt_data === e[15:0], "payload word");
        if (text_mode) check({last1, last0} === {CH_CR, CH_LF}, "text terminator");
        else check(nbytes === 5 + pkt_len, "binary frame size");
      end
      nbytes = 0;
    end
    if (cmd_stb === 1'b1 || cmd_bad === 1'b1) begin
      if (dev_q.size() == 0) check(1'b0, "command with none expected");
      else check(cmd_stb === 1'b1 && {cmd_group, cmd_id, cmd_len} === dev_q.pop_front(), "command fields");
    end
    if (d2_bad === 1'b1) n_bad++;
    if (d2_stb === 1'b1) begin
      n_good++;
      check({d2_group, d2_id, d2_len} === {8'h05, 8'h06, CMD_LEN}, "far command fields");
    end
  end
  // main sequence
  initial begin
    int n;
    lk2.h2d_stb = 1'b0;
    lk2.h2d_byte = 8'h00;
    lk2.host_rts = 1'b1;
    lk2.serial_profile_select_n = 1'b1;
    lk2.low_power_select = 1'b0;
    void'($urandom(32'hAC99));
    host_q.push_back({2'b01, 43'h0});
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    settle(2000);
    // commands and events in text then binary format
    for (int m = 0; m < 2; m++) begin
      text_mode <= (m == 0);
      @(posedge clock);
      for (int k = 0; k < 3; k++) begin
        send_cmd(8'($urandom), 8'($urandom));
        settle(2000);
        send_evt(8'($urandom), 8'($urandom), 16'($urandom));
        settle(2000);
      end
    end
    // event raised while a command arrives waits for the response
    send_cmd(8'h11, 8'h22);
    for (n = 0; n < 100 && link.h2d_stb !== 1'b1; n++) @(negedge clock);
    check(n < 100, "no command byte");
    @(posedge clock);
    send_evt(8'h44, 8'h55, 16'hBEEF);
    settle(2000);
    // api disabled holds the event back
    profile_req <= 1'b1;
    repeat (3) @(posedge clock);
    send_evt(8'h02, 8'h07, 16'h1234);
    repeat (300) @(posedge clock);
    check(host_q.size() == 1 && api_active === 1'b0, "output with api off");
    profile_req <= 1'b0;
    settle(2000);
    // sleep only when allowed
    no_sleep <= 1'b1;
    repeat (20) @(posedge clock);
    check(sleeping === 1'b0, "slept while held awake");
    no_sleep <= 1'b0;
    repeat (20) @(posedge clock);
    check(sleeping === 1'b1, "no sleep when idle");
    // far end: bad checksum frame, then a good one with a long gap
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 7; k++) begin
        lk2.h2d_byte <= (k == 6) ? 8'h17 + 8'(m == 0) : frm[k];
        lk2.h2d_stb <= 1'b1;
        @(posedge clock);
        lk2.h2d_stb <= 1'b0;
        repeat ((m == 1 && k == 3) ? 300 : 3) @(posedge clock);
      end
    end
    repeat (5) @(posedge clock);
    check(n_bad === 1 && n_good === 1, "checksum handling");
    finish_test();
  end
endmodule : testbench

// ===== dv/uaf_link_sva.sv
// timing checks on the link between the module end and the host end
`timescale 1ns/1ps
module uaf_link_sva import uaf_pkg::*; (
  input wire logic clock, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic [7:0] d2h_byte, // module to host byte
  input wire logic d2h_stb, // module byte strobe
  input wire logic [7:0] h2d_byte, // host to module byte
  input wire logic h2d_stb, // host byte strobe
  input wire logic dev_rts, // module ready
  input wire logic host_rts, // host ready
  input wire logic serial_profile_select_n, // low disables the api
  input wire logic low_power_select // high forbids sleep
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // module ready mirrors the profile select one cycle late
  property p_rts_follow;
    $past(!sys_rst) |-> dev_rts == $past(serial_profile_select_n);
  endproperty
  a_rts_follow: assert property (p_rts_follow) else $error("ready not following select");
  // no module byte while the api stays disabled
  property p_api_quiet;
    !serial_profile_select_n [*3] |=> !d2h_stb;
  endproperty
  a_api_quiet: assert property (p_api_quiet) else $error("byte sent with api off");
  // module bytes only after host clear-to-send
  property p_stb_cts;
    d2h_stb |-> $past(host_rts) && $past(serial_profile_select_n);
  endproperty
  a_stb_cts: assert property (p_stb_cts) else $error("byte sent without host ready");
  // module bytes paced by the byte time
  property p_d2h_pace;
    d2h_stb |=> !d2h_stb [*8];
  endproperty
  a_d2h_pace: assert property (p_d2h_pace) else $error("module bytes too close");
  // host bytes only after module ready
  property p_h2d_cts;
    h2d_stb |-> $past(dev_rts);
  endproperty
  a_h2d_cts: assert property (p_h2d_cts) else $error("host byte without module ready");
  // host bytes paced by the byte time
  property p_h2d_pace;
    h2d_stb |=> !h2d_stb [*8];
  endproperty
  a_h2d_pace: assert property (p_h2d_pace) else $error("host bytes too close");
  // byte value stands between strobes
  property p_byte_hold;
    !d2h_stb |-> $stable(d2h_byte);
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("module byte changed between strobes");
  // boot event starts soon after reset when api enabled
  property p_boot_evt;
    $fell(sys_rst) && serial_profile_select_n |-> ##[1:200] (d2h_stb && (d2h_byte == CH_AT || d2h_byte == 8'h80));
  endproperty
  a_boot_evt: assert property (p_boot_evt) else $error("no boot event after reset");
endmodule : uaf_link_sva

// ===== hw/uaf_device.sv
// module end of the link: command parser, packet generator and transmit fifo
`timescale 1ns/1ps
module uaf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic in_valid, // write request
  input wire logic [W-1:0] in_data, // write word
  output logic in_ready, // room left
  output logic out_valid, // word available
  output logic [W-1:0] out_data, // head word
  input wire logic out_ready // read accept
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } uaf_fifo_st_t;
  uaf_fifo_st_t r, n;
  logic push, pop;

  // pointers and count
  always_comb begin
    n = r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = r.wp + 1'b1;
    end
    if (pop) n.rp = r.rp + 1'b1;
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) r <= '0;
    else r <= n;
  end

  assign in_ready = r.cnt != (AW+1)'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign out_data = r.mem[r.rp];
endmodule : uaf_fifo

module uaf_device import uaf_pkg::*; #(
  parameter int BAUD = BAUD_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic sys_rst, // sync reset, active high
  uaf_link_if.device link, // link to the host
  input wire logic text_mode, // 1 text format, 0 binary
  input wire logic evt_req, // event request pulse
  input wire logic [7:0] evt_group, // event group
  input wire logic [7:0] evt_id, // event identifier
  input wire logic [15:0] evt_data, // event payload word
  output logic evt_ready, // event slot free
  output logic cmd_stb, // valid command pulse
  output logic cmd_bad, // rejected command pulse
  output logic [7:0] cmd_group, // command group
  output logic [7:0] cmd_id, // command identifier
  output logic [10:0] cmd_len, // command payload length
  output logic sleeping, // sleep state
  output logic api_active // api enabled
);
  localparam int BYTE_CYC = CLK_HZ / BAUD * BITS_PER_BYTE;
  if (BYTE_CYC < 1 || BYTE_CYC > 4095) $error("baud rate out of range");
  if (RSP_LEN > PAY_EMIT_MAX || EVT_LEN > PAY_EMIT_MAX) $error("payload too long");
  localparam logic [11:0] BYTE_LAST = 12'(BYTE_CYC - 1);

  typedef enum logic [1:0] {RX_HDR, RX_PAY, RX_SUM} uaf_rx_t;
  typedef struct packed {
    uaf_rx_t st;
    logic [1:0] hcnt;
    logic [1:0] rtype;
    logic [10:0] len;
    logic [10:0] pcnt;
    logic [7:0] grp;
    logic [7:0] id;
    logic [7:0] sum;
    logic line_full;
    logic line_bad;
    logic after_cr;
    logic rsp_pend;
    logic [7:0] rsp_grp;
    logic [7:0] rsp_id;
    logic boot_pend;
    logic first;
    logic evt_pend;
    logic [7:0] evt_grp;
    logic [7:0] evt_id;
    logic [15:0] evt_data;
    logic tx_busy;
    logic tx_txt;
    logic [1:0] tx_type;
    logic [3:0] tx_idx;
    logic [7:0] tx_grp;
    logic [7:0] tx_id;
    logic [15:0] tx_data;
    logic [10:0] tx_len;
    logic [7:0] tx_sum;
    logic [11:0] baud_cnt;
    logic [7:0] d2h_byte;
    logic d2h_stb;
    logic rts;
    logic api;
    logic sleeping;
    logic cmd_stb;
    logic cmd_bad;
    logic [7:0] cmd_grp;
    logic [7:0] cmd_id;
    logic [10:0] cmd_len;
    logic evt_ready;
  } uaf_dev_st_t;
  uaf_dev_st_t r, n;

  logic tick, api, pop_rdy, cmd_busy, f_in_ready, f_out_valid;
  logic [7:0] f_out_data, gbyte, b;
  logic [3:0] glast;

  // transmit queue; generator stalls when it fills
  uaf_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(r.tx_busy),
    .in_data(gbyte),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(pop_rdy)
  );

  // byte of the packet being generated
  always_comb begin
    glast = r.tx_txt ? TXT_LAST : HDR_BYTES + r.tx_len[3:0];
    gbyte = CH_LF;
    if (r.tx_txt) begin
      unique case (r.tx_idx)
        4'h0: gbyte = CH_AT;
        4'h1: gbyte = (r.tx_type == PT_EVT) ? CH_E : CH_R;
        4'h2: gbyte = CH_COMMA;
        4'h3: gbyte = hex_char(r.tx_grp[7:4]);
        4'h4: gbyte = hex_char(r.tx_grp[3:0]);
        4'h5: gbyte = hex_char(r.tx_id[7:4]);
        4'h6: gbyte = hex_char(r.tx_id[3:0]);
        4'h7: gbyte = CH_CR;
        default: gbyte = CH_LF;
      endcase
    end else begin
      unique case (r.tx_idx)
        4'h0: gbyte = hdr0(r.tx_type, r.tx_len);
        4'h1: gbyte = r.tx_len[7:0];
        4'h2: gbyte = r.tx_grp;
        4'h3: gbyte = r.tx_id;
        default: begin
          if (r.tx_idx == glast) gbyte = r.tx_sum;
          else if (r.tx_idx == HDR_BYTES) gbyte = r.tx_data[7:0];
          else gbyte = r.tx_data[15:8];
        end
      endcase
    end
  end

  // parser, arbiter, pacing and status
  always_comb begin
    n = r;
    b = link.h2d_byte;
    n.d2h_stb = 1'b0;
    n.cmd_stb = 1'b0;
    n.cmd_bad = 1'b0;
    api = link.serial_profile_select_n;
    n.api = api;
    n.rts = api;
    tick = r.baud_cnt == '0;
    n.baud_cnt = tick ? BYTE_LAST : r.baud_cnt - 12'h001;
    pop_rdy = tick && link.host_rts && api;
    if (pop_rdy && f_out_valid) begin
      n.d2h_byte = f_out_data;
      n.d2h_stb = 1'b1;
    end
    cmd_busy = text_mode ? r.line_full : (r.st != RX_HDR || r.hcnt != '0);
    // boot event only if the api was enabled when reset released
    if (r.first) begin
      n.first = 1'b0;
      if (!api) n.boot_pend = 1'b0;
    end
    // one packet at a time, response before anything else
    if (!r.tx_busy) begin
      n.tx_idx = '0;
      n.tx_sum = '0;
      n.tx_txt = text_mode;
      if (r.rsp_pend) begin
        n.rsp_pend = 1'b0;
        n.tx_busy = 1'b1;
        n.tx_type = PT_RSP;
        n.tx_grp = r.rsp_grp;
        n.tx_id = r.rsp_id;
        n.tx_data = RESULT_OK;
        n.tx_len = RSP_LEN;
      end else if (!cmd_busy && r.boot_pend && api && !r.first) begin
        n.boot_pend = 1'b0;
        n.tx_busy = 1'b1;
        n.tx_type = PT_EVT;
        n.tx_grp = BOOT_GROUP;
        n.tx_id = BOOT_ID;
        n.tx_data = '0;
        n.tx_len = BOOT_LEN;
      end else if (!cmd_busy && r.evt_pend) begin
        n.evt_pend = 1'b0;
        n.tx_busy = 1'b1;
        n.tx_type = PT_EVT;
        n.tx_grp = r.evt_grp;
        n.tx_id = r.evt_id;
        n.tx_data = r.evt_data;
        n.tx_len = EVT_LEN;
      end
    end else if (f_in_ready) begin
      n.tx_idx = r.tx_idx + 4'h1;
      n.tx_sum = r.tx_sum + gbyte;
      if (r.tx_idx == glast) n.tx_busy = 1'b0;
    end
    // command receive
    if (api && link.h2d_stb) begin
      if (text_mode) begin
        if (b == CH_CR || b == CH_LF) begin
          if (!(b == CH_LF && r.after_cr)) begin
            if (r.line_full) begin
              if (r.line_bad) n.cmd_bad = 1'b1;
              else begin
                n.rsp_pend = 1'b1;
                n.rsp_grp = '0;
                n.rsp_id = '0;
                n.cmd_stb = 1'b1;
                n.cmd_grp = '0;
                n.cmd_id = '0;
                n.cmd_len = '0;
              end
            end
            n.line_full = 1'b0;
            n.line_bad = 1'b0;
          end
          n.after_cr = b == CH_CR;
        end else begin
          n.line_full = 1'b1;
          n.after_cr = 1'b0;
          if (!is_printable(b)) n.line_bad = 1'b1;
        end
      end else begin
        n.sum = r.sum + b;
        unique case (r.st)
          RX_HDR: begin
            n.hcnt = r.hcnt + 2'h1;
            unique case (r.hcnt)
              2'h0: begin
                n.sum = b;
                n.rtype = b[TYPE_LSB +: 2];
                n.len[LEN_W-1:LEN_W-LENHI_W] = b[LENHI_W-1:0];
              end
              2'h1: n.len[7:0] = b;
              2'h2: n.grp = b;
              default: begin
                n.id = b;
                n.pcnt = r.len;
                n.st = (r.len == '0) ? RX_SUM : RX_PAY;
              end
            endcase
          end
          RX_PAY: begin
            n.pcnt = r.pcnt - 11'h001;
            if (r.pcnt == 11'h001) n.st = RX_SUM;
          end
          RX_SUM: begin
            n.st = RX_HDR;
            n.hcnt = '0;
            if (b == r.sum && r.rtype == PT_CMD) begin
              n.rsp_pend = 1'b1;
              n.rsp_grp = r.grp;
              n.rsp_id = r.id;
              n.cmd_stb = 1'b1;
              n.cmd_grp = r.grp;
              n.cmd_id = r.id;
              n.cmd_len = r.len;
            end else n.cmd_bad = 1'b1;
          end
        endcase
      end
    end
    // user event slot; a request in the freeing cycle is kept
    if (evt_req && !n.evt_pend) begin
      n.evt_pend = 1'b1;
      n.evt_grp = evt_group;
      n.evt_id = evt_id;
      n.evt_data = evt_data;
    end
    n.evt_ready = !n.evt_pend;
    n.sleeping = !link.low_power_select && !n.tx_busy && !f_out_valid && !n.rsp_pend
      && !n.evt_pend && !n.boot_pend && !cmd_busy;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= RX_HDR;
      r.boot_pend <= 1'b1;
      r.first <= 1'b1;
    end else r <= n;
  end

  // outputs straight from state
  assign link.d2h_byte = r.d2h_byte;
  assign link.d2h_stb = r.d2h_stb;
  assign link.dev_rts = r.rts;
  assign evt_ready = r.evt_ready;
  assign cmd_stb = r.cmd_stb;
  assign cmd_bad = r.cmd_bad;
  assign cmd_group = r.cmd_grp;
  assign cmd_id = r.cmd_id;
  assign cmd_len = r.cmd_len;
  assign sleeping = r.sleeping;
  assign api_active = r.api;
endmodule : uaf_device

// ===== hw/uaf_host.sv
// host end of the link: command generator and reply/event parser
`timescale 1ns/1ps
module uaf_host import uaf_pkg::*; #(
  parameter int BAUD = BAUD_DEF
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic sys_rst, // sync reset, active high
  uaf_link_if.host link, // link to the module
  input wire logic text_mode, // 1 text format, 0 binary
  input wire logic profile_req, // ask for serial profile mode
  input wire logic no_sleep, // hold module awake
  input wire logic cmd_req, // send command pulse
  input wire logic [7:0] cmd_group, // command group
  input wire logic [7:0] cmd_id, // command identifier
  input wire logic [7:0] cmd_arg, // single array byte
  output logic cmd_ready, // generator idle
  output logic pkt_stb, // packet received pulse
  output logic pkt_evt, // packet was an event
  output logic [7:0] pkt_group, // packet group
  output logic [7:0] pkt_id, // packet identifier
  output logic [10:0] pkt_len, // payload length
  output logic [15:0] pkt_data, // first payload word
  output logic pkt_bad // checksum failure pulse
);
  localparam int BYTE_CYC = CLK_HZ / BAUD * BITS_PER_BYTE;
  if (BYTE_CYC < 1 || BYTE_CYC > 4095) $error("baud rate out of range");
  localparam logic [11:0] BYTE_LAST = 12'(BYTE_CYC - 1);

  typedef enum logic [1:0] {HR_HDR, HR_PAY, HR_SUM} uaf_hrx_t;
  typedef struct packed {
    uaf_hrx_t st;
    logic [1:0] hcnt;
    logic [1:0] rtype;
    logic [10:0] len;
    logic [10:0] pcnt;
    logic [7:0] grp;
    logic [7:0] id;
    logic [15:0] data;
    logic [7:0] sum;
    logic [1:0] tpos;
    logic tevt;
    logic busy;
    logic txt;
    logic [3:0] idx;
    logic [7:0] tgrp;
    logic [7:0] tid;
    logic [7:0] targ;
    logic [7:0] tsum;
    logic [11:0] baud_cnt;
    logic [7:0] h2d_byte;
    logic h2d_stb;
    logic rts;
    logic sps_n;
    logic lps;
    logic cmd_ready;
    logic pkt_stb;
    logic pkt_evt;
    logic [7:0] pkt_grp;
    logic [7:0] pkt_id;
    logic [10:0] pkt_len;
    logic [15:0] pkt_data;
    logic pkt_bad;
  } uaf_host_st_t;
  uaf_host_st_t r, n;
  logic [7:0] tb, b;
  logic [3:0] tlast;
  logic [10:0] pidx;

  // command byte at the current index
  always_comb begin
    tlast = r.txt ? HOST_TXT_LAST : HOST_BIN_LAST;
    tb = r.tsum;
    if (r.txt) begin
      unique case (r.idx)
        4'h0: tb = CH_SLASH;
        4'h1: tb = hex_char(r.tgrp[7:4]);
        4'h2: tb = hex_char(r.tgrp[3:0]);
        4'h3: tb = hex_char(r.tid[7:4]);
        4'h4: tb = hex_char(r.tid[3:0]);
        default: tb = CH_CR;
      endcase
    end else begin
      unique case (r.idx)
        4'h0: tb = hdr0(PT_CMD, CMD_LEN);
        4'h1: tb = CMD_LEN[7:0];
        4'h2: tb = r.tgrp;
        4'h3: tb = r.tid;
        4'h4: tb = ARG_LEN;
        4'h5: tb = r.targ;
        default: tb = r.tsum;
      endcase
    end
  end

  // generator, parser and pins
  always_comb begin
    n = r;
    b = link.d2h_byte;
    pidx = r.len - r.pcnt;
    n.h2d_stb = 1'b0;
    n.pkt_stb = 1'b0;
    n.pkt_bad = 1'b0;
    n.rts = 1'b1;
    n.sps_n = !profile_req;
    n.lps = no_sleep;
    n.baud_cnt = (r.baud_cnt == '0) ? BYTE_LAST : r.baud_cnt - 12'h001;
    // one byte per byte time while the module is ready
    if (r.busy) begin
      if (r.baud_cnt == '0 && link.dev_rts) begin
        n.h2d_byte = tb;
        n.h2d_stb = 1'b1;
        n.idx = r.idx + 4'h1;
        n.tsum = r.tsum + tb;
        if (r.idx == tlast) n.busy = 1'b0;
      end
    end else if (cmd_req) begin
      n.busy = 1'b1;
      n.txt = text_mode;
      n.idx = '0;
      n.tsum = '0;
      n.tgrp = cmd_group;
      n.tid = cmd_id;
      n.targ = cmd_arg;
    end
    n.cmd_ready = !n.busy;
    // reply and event parser
    if (link.d2h_stb) begin
      if (text_mode) begin
        if (b == CH_LF) begin
          if (r.tpos != '0) begin
            n.pkt_stb = 1'b1;
            n.pkt_evt = r.tevt;
            n.pkt_grp = '0;
            n.pkt_id = '0;
            n.pkt_len = '0;
            n.pkt_data = '0;
          end
          n.tpos = '0;
          n.tevt = 1'b0;
        end else if (b != CH_CR) begin
          if (r.tpos == 2'h1) n.tevt = b == CH_E;
          if (r.tpos != 2'h3) n.tpos = r.tpos + 2'h1;
        end
      end else begin
        n.sum = r.sum + b;
        unique case (r.st)
          HR_HDR: begin
            n.hcnt = r.hcnt + 2'h1;
            unique case (r.hcnt)
              2'h0: begin
                n.sum = b;
                n.data = '0;
                n.rtype = b[TYPE_LSB +: 2];
                n.len[LEN_W-1:LEN_W-LENHI_W] = b[LENHI_W-1:0];
              end
              2'h1: n.len[7:0] = b;
              2'h2: n.grp = b;
              default: begin
                n.id = b;
                n.pcnt = r.len;
                n.st = (r.len == '0) ? HR_SUM : HR_PAY;
              end
            endcase
          end
          HR_PAY: begin
            if (pidx == 11'h000) n.data[7:0] = b;
            if (pidx == 11'h001) n.data[15:8] = b;
            n.pcnt = r.pcnt - 11'h001;
            if (r.pcnt == 11'h001) n.st = HR_SUM;
          end
          HR_SUM: begin
            n.st = HR_HDR;
            n.hcnt = '0;
            if (b == r.sum) begin
              n.pkt_stb = 1'b1;
              n.pkt_evt = r.rtype == PT_EVT;
              n.pkt_grp = r.grp;
              n.pkt_id = r.id;
              n.pkt_len = r.len;
              n.pkt_data = r.data;
            end else n.pkt_bad = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= HR_HDR;
      r.sps_n <= 1'b1;
    end else r <= n;
  end

  // outputs straight from state
  assign link.h2d_byte = r.h2d_byte;
  assign link.h2d_stb = r.h2d_stb;
  assign link.host_rts = r.rts;
  assign link.serial_profile_select_n = r.sps_n;
  assign link.low_power_select = r.lps;
  assign cmd_ready = r.cmd_ready;
  assign pkt_stb = r.pkt_stb;
  assign pkt_evt = r.pkt_evt;
  assign pkt_group = r.pkt_grp;
  assign pkt_id = r.pkt_id;
  assign pkt_len = r.pkt_len;
  assign pkt_data = r.pkt_data;
  assign pkt_bad = r.pkt_bad;
endmodule : uaf_host

// ===== hw/uaf_link_if.sv
// byte-level link between the module end and the host end
`timescale 1ns/1ps
interface uaf_link_if;
  logic [7:0] d2h_byte; // module to host byte
  logic d2h_stb; // one-cycle byte strobe
  logic [7:0] h2d_byte; // host to module byte
  logic h2d_stb; // one-cycle byte strobe
  logic dev_rts; // module ready, seen by host as clear-to-send
  logic host_rts; // host ready, seen by module as clear-to-send
  logic serial_profile_select_n; // low disables the api
  logic low_power_select; // high forbids sleep
  modport device (output d2h_byte, d2h_stb, dev_rts,
                  input h2d_byte, h2d_stb, host_rts, serial_profile_select_n, low_power_select);
  modport host (input d2h_byte, d2h_stb, dev_rts,
                output h2d_byte, h2d_stb, host_rts, serial_profile_select_n, low_power_select);
endinterface : uaf_link_if

// ===== hw/uaf_pkg.sv
// shared constants, encodings and helpers for the host link framer
package uaf_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_DEF = 115_200;
  localparam int BITS_PER_BYTE = 10; // start, eight data, stop
  localparam int LEN_W = 11;
  localparam int PAY_MAX = 2047;
  localparam int PAY_EMIT_MAX = 520;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int TYPE_LSB = 6;
  localparam int LENHI_W = 3;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_TILDE = 8'h7E;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_A_OFS = 8'h37;
  localparam logic [3:0] HEX_TEN = 4'hA;
  localparam logic [1:0] PT_CMD = 2'h0;
  localparam logic [1:0] PT_RSP = 2'h1;
  localparam logic [1:0] PT_EVT = 2'h2;
  localparam logic [7:0] BOOT_GROUP = 8'h02;
  localparam logic [7:0] BOOT_ID = 8'h01;
  localparam logic [10:0] RSP_LEN = 11'h002;
  localparam logic [10:0] EVT_LEN = 11'h002;
  localparam logic [10:0] BOOT_LEN = 11'h000;
  localparam logic [10:0] CMD_LEN = 11'h002;
  localparam logic [15:0] RESULT_OK = 16'h0000;
  localparam logic [7:0] ARG_LEN = 8'h01; // one-byte prefix of a short_byte_array
  localparam logic [3:0] HDR_BYTES = 4'h4;
  localparam logic [3:0] TXT_LAST = 4'h8;
  localparam logic [3:0] HOST_TXT_LAST = 4'h5;
  localparam logic [3:0] HOST_BIN_LAST = 4'h6;

  // ascii hex digit for a nibble
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < HEX_TEN) ? CH_0 + {4'h0, n} : CH_A_OFS + {4'h0, n};
  endfunction : hex_char

  // printable ascii test
  function automatic logic is_printable(input logic [7:0] b);
    is_printable = (b >= CH_SP) && (b <= CH_TILDE);
  endfunction : is_printable

  // first header byte: type in the top bits, length bits 10..8 at the bottom
  function automatic logic [7:0] hdr0(input logic [1:0] t, input logic [10:0] len);
    hdr0 = {t, 3'h0, len[LEN_W-1:LEN_W-LENHI_W]};
  endfunction : hdr0
endpackage : uaf_pkg
